// [verilog/host_request_and_command_vector.sv]
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: Receive enable with receive-full raises the receive request line.
// RULE2: Receive enable clear means receive-full never raises a request.
// RULE3: Transmit enable with transmit-empty raises the transmit request line.
// RULE4: Double-request clear: shared request; set: separate tx and rx lines.
// RULE5: Eight-bit read/write command vector selects one of 128 routines.
// RULE6: Command path is independent of all data transfer state.
// RULE7: Host sets handshake bit 7; device clears it on core acknowledge.
// RULE8: Host must not rewrite the vector until handshake bit clears.
// RULE9: Setting handshake bit sets the core-side command-pending flag.
// RULE10: Handshake bit and vector field are written in one cycle.
// RULE11: Routine address supplied to the core is twice the vector.
// RULE12: Reset clears handshake and loads vector with 0x32.
// RULE13: Pending held until acknowledge; then pending and handshake clear.
module host_request_and_command_vector (
    input wire logic clock_i, // 20 MHz clock
    input wire logic rst_i, // Synchronous reset, all reset kinds
    input wire logic [3:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    input wire logic receive_full_flag_i, // Receive registers full
    input wire logic transmit_empty_flag_i, // Transmit registers empty
    input wire logic host_acknowledge_pin_i, // Acknowledge pin, single mode
    input wire logic core_ack_i, // Core accepts command interrupt
    output logic core_command_pending_o, // Command request to core
    output logic [7:0] core_vector_addr_o, // Routine address to core
    output logic shared_host_request_pin_o, // Shared or transmit req
    output logic receive_request_pin_o, // Receive req, split mode
    output logic receive_request_pin_oe_o, // Drive enable of that pin
    output logic irq_o // Level interrupt
);
    // =========================================================
    // Registers
    // =========================================================
    logic handshake_reg;
    logic [6:0] vector_reg;
    logic [2:0] req_ctrl_reg;
    logic [1:0] ev_status_reg;
    logic [1:0] ev_mask_reg;
    logic [7:0] rdata_reg;
    logic ack_level;
    logic rx_req;
    logic tx_req;
    logic cmd_write;
    logic cmd_taken;
    logic status_read;
    logic [1:0] ev_now;

    // Acknowledge pin comes from outside, so it is synchronised
    pin_sync ack_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(host_acknowledge_pin_i),
        .level_o(ack_level)
    );

    // =========================================================
    // Host command vector
    // =========================================================
    assign cmd_write = wr_i && (addr_i == host_req_pkg::ADDR_CMD_VECTOR);
    assign cmd_taken = handshake_reg && core_ack_i;

    // Vector is frozen while a command is pending so the core sees a
    // stable address; a host that breaks the handshake cannot corrupt it.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            vector_reg <= host_req_pkg::VECTOR_RESET; // RULE12
        end else if (cmd_write && !handshake_reg) begin
            vector_reg <= wdata_i[host_req_pkg::VECTOR_MSB:0]; // RULE10
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            handshake_reg <= 1'b0; // RULE12
        end else if (cmd_taken) begin
            handshake_reg <= 1'b0; // RULE7 RULE13
        end else if (cmd_write && !handshake_reg) begin
            handshake_reg <= wdata_i[host_req_pkg::HANDSHAKE_BIT]; // RULE10
        end
    end

    // Pending flag is the handshake bit seen from the core side
    assign core_command_pending_o = handshake_reg; // RULE9 RULE13
    assign core_vector_addr_o = {vector_reg, 1'b0}; // RULE11 RULE5

    // =========================================================
    // Request control and request pins
    // =========================================================
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            req_ctrl_reg <= host_req_pkg::REQ_CTRL_RESET;
        end else if (wr_i && (addr_i == host_req_pkg::ADDR_REQ_CTRL)) begin
            req_ctrl_reg <= wdata_i[host_req_pkg::DOUBLE_BIT:0];
        end
    end

    // Request terms use only the enable bits and data flags, never the command path
    assign rx_req = req_ctrl_reg[host_req_pkg::RX_EN_BIT]
                    && receive_full_flag_i; // RULE1 RULE2 RULE6
    assign tx_req = req_ctrl_reg[host_req_pkg::TX_EN_BIT]
                    && transmit_empty_flag_i; // RULE3

    always_comb begin
        if (req_ctrl_reg[host_req_pkg::DOUBLE_BIT]) begin
            shared_host_request_pin_o = tx_req; // RULE4 RULE3
            receive_request_pin_o = rx_req; // RULE1
            receive_request_pin_oe_o = 1'b1; // RULE4
        end else begin
            shared_host_request_pin_o = tx_req || rx_req; // RULE4 RULE1
            receive_request_pin_o = 1'b0;
            receive_request_pin_oe_o = 1'b0; // RULE4
        end
    end

    // =========================================================
    // Interrupt status and mask
    // =========================================================
    assign status_read = rd_i && (addr_i == host_req_pkg::ADDR_IRQ_STATUS);
    assign ev_now = {cmd_write && !handshake_reg
                     && wdata_i[host_req_pkg::HANDSHAKE_BIT], cmd_taken};

    // New events win over the clearing read
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ev_status_reg <= 2'h0;
        end else if (status_read) begin
            ev_status_reg <= ev_now;
        end else begin
            ev_status_reg <= ev_status_reg | ev_now;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ev_mask_reg <= 2'h0;
        end else if (wr_i && (addr_i == host_req_pkg::ADDR_IRQ_MASK)) begin
            ev_mask_reg <= wdata_i[host_req_pkg::EV_WIDTH-1:0];
        end
    end

    assign irq_o = |(ev_status_reg & ev_mask_reg);

    // =========================================================
    // Read port
    // =========================================================
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                host_req_pkg::ADDR_CMD_VECTOR: begin
                    rdata_reg <= {handshake_reg, vector_reg}; // RULE5 RULE7
                end
                host_req_pkg::ADDR_REQ_CTRL: begin
                    rdata_reg <= {5'h00, req_ctrl_reg};
                end
                host_req_pkg::ADDR_FLAGS: begin
                    rdata_reg <= {4'h0, ack_level, rx_req, tx_req,
                                  shared_host_request_pin_o};
                end
                host_req_pkg::ADDR_IRQ_STATUS: begin
                    rdata_reg <= {6'h00, ev_status_reg};
                end
                host_req_pkg::ADDR_IRQ_MASK: begin
                    rdata_reg <= {6'h00, ev_mask_reg};
                end
                default: begin
                    rdata_reg <= 8'h00;
                end
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_o = rdata_reg;

    // =========================================================
    // Checks
    // =========================================================
    // One clock domain, so every check shares clock and reset
    default clocking chk_clk @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Host posts a command while the core is not acknowledging
    sequence s_cmd_set;
        cmd_write && !handshake_reg
        && wdata_i[host_req_pkg::HANDSHAKE_BIT] && !core_ack_i;
    endsequence

    // Core takes the pending command
    sequence s_cmd_ack;
        handshake_reg && core_ack_i;
    endsequence

    // Nothing pending on either side
    sequence s_cmd_idle;
        !handshake_reg && !core_command_pending_o;
    endsequence

    chk_rx_request: assert property ( // RULE1
        (req_ctrl_reg[host_req_pkg::RX_EN_BIT] && receive_full_flag_i)
        |-> (shared_host_request_pin_o || receive_request_pin_o))
        else $error("receive request missing");

    chk_rx_disabled: assert property ( // RULE2
        (!req_ctrl_reg[host_req_pkg::RX_EN_BIT] && !tx_req)
        |-> (!shared_host_request_pin_o && !receive_request_pin_o))
        else $error("request without enable");

    chk_tx_request: assert property ( // RULE3
        (req_ctrl_reg[host_req_pkg::TX_EN_BIT] && transmit_empty_flag_i)
        |-> shared_host_request_pin_o)
        else $error("transmit request missing");

    chk_split_mode: assert property ( // RULE4
        !req_ctrl_reg[host_req_pkg::DOUBLE_BIT]
        |-> !receive_request_pin_oe_o)
        else $error("rx pin driven in shared mode");

    chk_cmd_pending: assert property ( // RULE9
        s_cmd_set
        |=> core_command_pending_o)
        else $error("pending not raised");

    chk_cmd_clear: assert property ( // RULE13
        s_cmd_ack
        |=> (!handshake_reg && !core_command_pending_o))
        else $error("handshake not cleared");

    chk_vector_hold: assert property ( // RULE8
        (handshake_reg && !core_ack_i)
        |=> $stable(vector_reg))
        else $error("vector changed while pending");

    chk_vector_addr: assert property ( // RULE11
        s_cmd_set |=> (core_vector_addr_o ==
            {$past(wdata_i[host_req_pkg::VECTOR_MSB:0]), 1'b0}))
        else $error("wrong routine address");

    chk_reset_vec: assert property ( // RULE12
        $past(rst_i)
        |-> (vector_reg == host_req_pkg::VECTOR_RESET && !handshake_reg))
        else $error("reset values wrong");

    chk_split_rx_pin: assert property ( // RULE1
        req_ctrl_reg[host_req_pkg::DOUBLE_BIT] |-> (receive_request_pin_o ==
            (req_ctrl_reg[host_req_pkg::RX_EN_BIT] && receive_full_flag_i)))
        else $error("split receive request wrong");

    chk_split_tx_pin: assert property ( // RULE3
        req_ctrl_reg[host_req_pkg::DOUBLE_BIT]
        |-> (shared_host_request_pin_o == (transmit_empty_flag_i
            && req_ctrl_reg[host_req_pkg::TX_EN_BIT])))
        else $error("split transmit request wrong");

    chk_shared_pin: assert property ( // RULE4
        !req_ctrl_reg[host_req_pkg::DOUBLE_BIT]
        |-> (!receive_request_pin_o
            && (shared_host_request_pin_o == (rx_req || tx_req))))
        else $error("shared request wrong");

    chk_split_oe: assert property ( // RULE4
        req_ctrl_reg[host_req_pkg::DOUBLE_BIT]
        |-> receive_request_pin_oe_o)
        else $error("rx pin not driven in split mode");

    chk_rx_off_split: assert property ( // RULE2
        !req_ctrl_reg[host_req_pkg::RX_EN_BIT]
        |-> !receive_request_pin_o)
        else $error("receive request while disabled");

    chk_pend_hold: assert property ( // RULE13
        (core_command_pending_o && !core_ack_i)
        |=> core_command_pending_o)
        else $error("pending dropped before acknowledge");

    chk_vector_load: assert property ( // RULE10
        (cmd_write && !handshake_reg)
        |=> ({handshake_reg, vector_reg} == $past(wdata_i)))
        else $error("command write not taken whole");

    chk_cmd_indep: assert property ( // RULE6
        (!cmd_write && !core_ack_i)
        |=> ($stable(handshake_reg) && $stable(vector_reg)))
        else $error("command state moved by data path");

    chk_cmd_sequence: assert property ( // RULE7
        s_cmd_set ##1 s_cmd_ack
        |=> s_cmd_idle)
        else $error("command handshake not closed");

    chk_ack_ignored: assert property ( // RULE13
        (!handshake_reg && core_ack_i && !cmd_write)
        |=> s_cmd_idle)
        else $error("stray acknowledge raised pending");

    chk_posted_event: assert property (
        s_cmd_set
        |=> ev_status_reg[host_req_pkg::EV_CMD_POSTED])
        else $error("posted event lost");

    chk_taken_event: assert property (
        s_cmd_ack
        |=> ev_status_reg[host_req_pkg::EV_CMD_TAKEN])
        else $error("taken event lost");

    chk_event_sticky: assert property (
        (ev_status_reg[host_req_pkg::EV_CMD_POSTED] && !status_read)
        |=> ev_status_reg[host_req_pkg::EV_CMD_POSTED])
        else $error("posted event not sticky");

    chk_status_clear: assert property (
        (status_read && !cmd_write && !core_ack_i)
        |=> (ev_status_reg == 2'h0))
        else $error("status not cleared by read");

    chk_irq_masked: assert property (
        (ev_mask_reg == 2'h0)
        |-> !irq_o)
        else $error("masked event raised interrupt");

    chk_read_idle: assert property (
        !rd_i
        |=> (rdata_o == 8'h00))
        else $error("read data outside read cycle");

    chk_read_vector: assert property ( // RULE5
        (rd_i && addr_i == host_req_pkg::ADDR_CMD_VECTOR)
        |=> (rdata_o == {$past(handshake_reg), $past(vector_reg)}))
        else $error("command vector read wrong");

    chk_read_unmapped: assert property (
        (rd_i && addr_i > host_req_pkg::ADDR_IRQ_MASK)
        |=> (rdata_o == 8'h00))
        else $error("unmapped read not zero");

    chk_mask_write: assert property (
        (wr_i && addr_i == host_req_pkg::ADDR_IRQ_MASK)
        |=> (ev_mask_reg == $past(wdata_i[host_req_pkg::EV_WIDTH-1:0])))
        else $error("mask write lost");

    chk_ctrl_write: assert property ( // RULE4
        (wr_i && addr_i == host_req_pkg::ADDR_REQ_CTRL)
        |=> (req_ctrl_reg == $past(wdata_i[host_req_pkg::DOUBLE_BIT:0])))
        else $error("request control write lost");

    chk_reset_addr: assert property ( // RULE12
        $past(rst_i)
        |-> (core_vector_addr_o == {host_req_pkg::VECTOR_RESET, 1'b0}))
        else $error("reset routine address wrong");

    chk_reset_ctrl: assert property (
        $past(rst_i)
        |-> (req_ctrl_reg == host_req_pkg::REQ_CTRL_RESET && !irq_o))
        else $error("reset control wrong");
endmodule

// [verilog/host_req_pkg.sv]
package host_req_pkg;
    // =========================================================
    // Register map
    // =========================================================
    localparam logic [3:0] ADDR_CMD_VECTOR = 4'h0;
    localparam logic [3:0] ADDR_REQ_CTRL = 4'h1;
    localparam logic [3:0] ADDR_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    // =========================================================
    // Command vector layout
    // =========================================================
    localparam int HANDSHAKE_BIT = 7;
    localparam int VECTOR_MSB = 6;
    localparam logic [6:0] VECTOR_RESET = 7'h32;
    // =========================================================
    // Request control layout
    // =========================================================
    localparam int RX_EN_BIT = 0;
    localparam int TX_EN_BIT = 1;
    localparam int DOUBLE_BIT = 2;
    localparam logic [2:0] REQ_CTRL_RESET = 3'h0;
    // =========================================================
    // Interrupt event bits
    // =========================================================
    localparam int EV_CMD_TAKEN = 0;
    localparam int EV_CMD_POSTED = 1;
    localparam int EV_WIDTH = 2;
endpackage

// [verilog/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync (
    input wire logic clock_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic async_i, // Raw input
    output logic level_o // Settled level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Change accepted once second and third stages agree
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end
endmodule

// [tb/host_side_model.sv]
`timescale 1ns/10ps
// ========================================
// Host processor: acknowledges a shared request
// ========================================
module host_side_model #(
    parameter int ACK_LAT = 2
) (
    input wire logic clock_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic req_i, // Shared request pin
    input wire logic split_i, // Split mode: pin is a request
    output logic ack_o // Acknowledge pin
);
    int cnt;
    always_ff @(posedge clock_i) begin
        if (rst_i || !req_i || split_i) begin
            cnt <= 0;
            ack_o <= 1'b0;
        end else if (cnt == ACK_LAT) begin
            ack_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rxf = 1'b0;
    logic txe = 1'b0;
    logic core_ack_i = 1'b0;
    logic ack_pin;
    logic [7:0] rdata_o;
    logic [7:0] vaddr;
    logic pend;
    logic shared;
    logic rxpin;
    logic rxoe;
    logic irq_o;
    logic rq;
    logic tq;
    int mismatches = 0;
    int tests_run = 0;

    always #25 clock_i = ~clock_i;

    host_request_and_command_vector dut (.clock_i(clock_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .receive_full_flag_i(rxf),
        .transmit_empty_flag_i(txe), .host_acknowledge_pin_i(ack_pin),
        .core_ack_i(core_ack_i), .core_command_pending_o(pend),
        .core_vector_addr_o(vaddr), .shared_host_request_pin_o(shared),
        .receive_request_pin_o(rxpin), .receive_request_pin_oe_o(rxoe),
        .irq_o(irq_o));
    host_side_model host (.clock_i(clock_i), .rst_i(rst_i),
        .req_i(shared), .split_i(rxoe), .ack_o(ack_pin));

    // ========================================
    // Bus tasks
    // ========================================
    task check(input logic [7:0] got, input logic [7:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s,
                     got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp, "read");
    endtask
    task reset_dut;
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
    endtask
    task test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ========================================
    // Tests
    // ========================================
    initial begin
        reset_dut();
        check(vaddr, 8'h64, "vector address");
        rd(host_req_pkg::ADDR_CMD_VECTOR, 8'h32);
        rd(4'hf, 8'h00);
        wr(host_req_pkg::ADDR_IRQ_MASK, 8'h03);
        rd(host_req_pkg::ADDR_IRQ_MASK, 8'h03);
        wr(host_req_pkg::ADDR_CMD_VECTOR, 8'h85);
        check(pend, 8'h01, "pending");
        check(vaddr, 8'h0a, "vector address");
        check(irq_o, 8'h01, "irq posted");
        // Rewrite while pending must be dropped
        wr(host_req_pkg::ADDR_CMD_VECTOR, 8'h07);
        rd(host_req_pkg::ADDR_CMD_VECTOR, 8'h85);
        // Data flags swept with a command still pending
        for (int i = 0; i < 32; i++) begin
            wr(host_req_pkg::ADDR_REQ_CTRL, {5'h00, i[2:0]});
            @(posedge clock_i);
            rxf <= i[3];
            txe <= i[4];
            #1;
            rq = i[0] & i[3];
            tq = i[1] & i[4];
            check({rxoe, rxpin, shared}, i[2] ? {1'b1, rq, tq} :
                  {2'b00, rq | tq}, "pins");
        end
        check(pend, 8'h01, "pending kept");
        check(vaddr, 8'h0a, "vector kept");
        wr(host_req_pkg::ADDR_REQ_CTRL, 8'h02);
        @(posedge clock_i);
        rxf <= 1'b0;
        repeat (10) @(posedge clock_i);
        rd(host_req_pkg::ADDR_FLAGS, 8'h0b);
        @(posedge clock_i);
        core_ack_i <= 1'b1;
        @(posedge clock_i);
        core_ack_i <= 1'b0;
        #1;
        check(pend, 8'h00, "pending cleared");
        rd(host_req_pkg::ADDR_CMD_VECTOR, 8'h05);
        rd(host_req_pkg::ADDR_IRQ_STATUS, 8'h03);
        check(irq_o, 8'h00, "irq cleared");
        rd(host_req_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr(host_req_pkg::ADDR_CMD_VECTOR, 8'h7f);
        check(vaddr, 8'hfe, "top vector");
        rd(host_req_pkg::ADDR_CMD_VECTOR, 8'h7f);
        wr(host_req_pkg::ADDR_CMD_VECTOR, 8'h9c);
        reset_dut();
        rd(host_req_pkg::ADDR_CMD_VECTOR, 8'h32);
        check(pend, 8'h00, "pending after reset");
        test_done();
    end

    // Whole run needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge clock_i);
        mismatches++;
        test_done();
    end
endmodule
